// >>> protect_pkg.sv
// Constants for the system protection monitors: register window, field
// positions, reset values and timing counts. Assumes a 250 MHz system clock.
// Contract
// - Registers sit in relocatable 4-Kbyte window
// - Base register answers at 0003FF00 CPU space
// - Config register: writable bits plus read-only status
// - Config bits steer freeze, show, selects, privilege
// - Reset status records latest reset cause
// - Bus monitor times every internal access
// - Four selectable external timeout limits
// - Timeout raises internal bus error only
// - External monitoring can be disabled
// - Halt from core forces system reset
// - Double fault reset can be disabled
// - No arbitration in acknowledge gives bus error
// - Watchdog expiry gives reset or level 7
// - Eight watchdog periods, watchdog can be disabled
// - Bus monitor limit spans 64 to 512 cycles
`default_nettype none
package protect_pkg;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam logic [31:0] BASE_REG_ADDR = 32'h0003ff00;
   localparam logic [3:0] FC_CPU_SPACE = 4'h7;
   localparam int unsigned WIN_BITS = 12;
   localparam int unsigned FC_SUPV_BIT = 2;
   localparam int unsigned BASE_VALID_BIT = 0;
   // Register offsets inside the window
   localparam logic [11:0] OFS_CONFIG = 12'h000;
   localparam logic [11:0] OFS_RST_STATUS = 12'h004;
   localparam logic [11:0] OFS_PROTECT = 12'h008;
   localparam logic [11:0] OFS_SERVICE = 12'h00c;
   // Configuration fields
   localparam int unsigned CFG_IARB_LSB = 0;
   localparam int unsigned CFG_SUPV_BIT = 7;
   localparam int unsigned CFG_SHOW_LSB = 8;
   localparam int unsigned CFG_CSF_BIT = 12;
   localparam int unsigned CFG_FRZ_BIT = 14;
   localparam int unsigned CFG_AVEC_LSB = 16;
   localparam int unsigned CFG_ST_RST_BIT = 29;
   localparam int unsigned CFG_ST_CYC_BIT = 30;
   localparam int unsigned CFG_ST_WD_BIT = 31;
   localparam logic [31:0] CFG_WR_MASK = 32'h007f538f;
   localparam logic [31:0] CFG_RESET = 32'h0000000f;
   // Reset status bits
   localparam int unsigned RST_INSTR_BIT = 1;
   localparam int unsigned RST_LOC_BIT = 2;
   localparam int unsigned RST_DBF_BIT = 4;
   localparam int unsigned RST_SW_BIT = 5;
   localparam int unsigned RST_POW_BIT = 6;
   localparam int unsigned RST_EXT_BIT = 7;
   localparam logic [7:0] RST_STATUS_RESET = 8'h40;
   // Protection control fields
   localparam int unsigned PROT_SWT_LSB = 0;
   localparam int unsigned PROT_SWRI_BIT = 3;
   localparam int unsigned PROT_SWE_BIT = 4;
   localparam int unsigned PROT_DBFE_BIT = 5;
   localparam int unsigned PROT_BME_BIT = 6;
   localparam int unsigned PROT_BMT_LSB = 8;
   localparam logic [31:0] PROT_WR_MASK = 32'h0000037f;
   localparam logic [31:0] PROT_RESET = 32'h00000000;
   // Service keys and timing
   localparam logic [7:0] WD_KEY_ARM = 8'h55;
   localparam logic [7:0] WD_KEY_FIRE = 8'haa;
   localparam int unsigned BM_W = 10;
   localparam logic [9:0] BM_MIN_CYCLES = 10'h040;
   localparam logic [9:0] ARB_WIN_CYCLES = 10'h010;
   localparam int unsigned WD_W = 24;
   localparam logic [23:0] WD_BASE_DEFAULT = 24'h000200;
   localparam logic [9:0] RST_HOLD_CYCLES = 10'h200;
   localparam logic [2:0] IRQ_LEVEL_WD = 3'h7;
   typedef enum logic {WD_IDLE = 1'b0, WD_ARMED = 1'b1} wd_seq_type;
endpackage : protect_pkg
`default_nettype wire

// >>> sync2.sv
// Two-flop synchroniser for pin-level inputs.
// Assumes inputs are quasi-static relative to clk_i.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Data
   input wire logic [W-1:0] d_i,
   input wire logic [W-1:0] rst_val_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d_i ^ rst_val_i;
         q_ff <= meta_ff;
      end
   end

   // Inverted storage keeps reset constant while idling at rst_val_i
   assign q_o = q_ff ^ rst_val_i;
endmodule : sync2
`default_nettype wire

// >>> cycle_timer.sv
// Up-counter that pulses once when limit_i running cycles have passed.
// Assumes limit_i is nonzero and stable while running.
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
   parameter int unsigned W = 10
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic restart_i,
   input wire logic run_i,
   input wire logic [W-1:0] limit_i,
   output logic expired_o
);
   logic [W-1:0] cnt_ff;
   logic exp_ff;
   logic hit;

   assign hit = run_i && !restart_i && (cnt_ff == limit_i - W'(1));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= '0;
      end else if (restart_i || hit) begin
         cnt_ff <= '0;
      end else if (run_i) begin
         cnt_ff <= cnt_ff + W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         exp_ff <= 1'b0;
      end else begin
         exp_ff <= hit;
      end
   end

   assign expired_o = exp_ff;
endmodule : cycle_timer
`default_nettype wire

// >>> sys_protect.sv
// System configuration and protection: register window, reset cause,
// bus monitor, spurious acknowledge check, double fault reset, watchdog.
// Assumes the core issues one bus cycle at a time on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sys_protect #(
   parameter logic [23:0] WD_BASE_CYCLES = protect_pkg::WD_BASE_DEFAULT
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [31:0] addr_i,
   input wire logic [3:0] function_code_bits_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Bus cycle supervision
   input wire logic cyc_start_i,
   input wire logic cyc_ext_i,
   input wire logic cyc_intack_i,
   input wire logic cyc_end_i,
   input wire logic intack_arb_i,
   input wire logic halt_i,
   output logic bus_err_o,
   output logic bus_error_pin_oe_o,
   // Reset sources and output
   input wire logic ext_rst_n_i,
   input wire logic clk_loss_i,
   input wire logic reset_instr_i,
   output logic sys_reset_o,
   // Watchdog interrupt
   output logic wd_irq_o,
   output logic [2:0] wd_irq_level_o,
   // Configuration outputs
   output logic [19:0] reg_base_o,
   output logic freeze_en_o,
   output logic [1:0] show_mode_o,
   output logic cs_func_o,
   output logic supv_only_o,
   output logic [3:0] iarb_o,
   output logic [6:0] autovec_o
);
   logic [19:0] base_address_field_ff;
   logic base_valid_ff;
   logic [31:0] module_config_reg_ff;
   logic [31:0] protect_ctrl_reg_ff;
   logic [7:0] reset_status_reg_ff;
   logic [31:0] rdata_ff;
   logic [31:0] rd_val;
   logic module_base_reg_hit;
   logic win_hit;
   logic priv_ok;
   logic cfg_sel;
   logic rst_sel;
   logic prot_sel;
   logic svc_sel;
   logic cyc_active_ff;
   logic cyc_ext_ff;
   logic cyc_intack_ff;
   logic arb_seen_ff;
   logic bus_err_ff;
   logic pin_oe_ff;
   logic bm_run;
   logic sp_run;
   logic bm_tmo;
   logic sp_tmo;
   logic [9:0] bm_limit;
   logic [1:0] pin_sync;
   logic ext_req;
   logic loc_req;
   logic dbf_req;
   logic sw_req;
   logic any_req;
   logic [9:0] rst_cnt_ff;
   logic [9:0] nxt_rst_cnt;
   logic sys_reset_ff;
   protect_pkg::wd_seq_type wd_seq_ff;
   logic wd_service;
   logic wd_tmo;
   logic wd_run;
   logic [23:0] wd_limit;
   logic wd_irq_ff;
   logic [2:0] wd_lvl_ff;
   logic swe;
   logic swri;
   logic dbfe;
   logic bme;

   assign swe = protect_ctrl_reg_ff[protect_pkg::PROT_SWE_BIT];
   assign swri = protect_ctrl_reg_ff[protect_pkg::PROT_SWRI_BIT];
   assign dbfe = protect_ctrl_reg_ff[protect_pkg::PROT_DBFE_BIT];
   assign bme = protect_ctrl_reg_ff[protect_pkg::PROT_BME_BIT];

   // Address decode
   assign priv_ok = !module_config_reg_ff[protect_pkg::CFG_SUPV_BIT]
                    || function_code_bits_i[protect_pkg::FC_SUPV_BIT];
   assign module_base_reg_hit = (function_code_bits_i == protect_pkg::FC_CPU_SPACE)
                     && (addr_i == protect_pkg::BASE_REG_ADDR);
   assign win_hit = (function_code_bits_i != protect_pkg::FC_CPU_SPACE) && base_valid_ff
                    && (addr_i[31:protect_pkg::WIN_BITS] == base_address_field_ff)
                    && priv_ok;
   assign cfg_sel = win_hit && (addr_i[11:0] == protect_pkg::OFS_CONFIG);
   assign rst_sel = win_hit && (addr_i[11:0] == protect_pkg::OFS_RST_STATUS);
   assign prot_sel = win_hit && (addr_i[11:0] == protect_pkg::OFS_PROTECT);
   assign svc_sel = win_hit && (addr_i[11:0] == protect_pkg::OFS_SERVICE);

   // Base register only alt_space_move on 4-Kbyte alignment
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         base_address_field_ff <= 20'h00000;
         base_valid_ff <= 1'b0;
      end else if (wr_i && module_base_reg_hit) begin
         base_address_field_ff <= wdata_i[31:protect_pkg::WIN_BITS];
         base_valid_ff <= wdata_i[protect_pkg::BASE_VALID_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         module_config_reg_ff <= protect_pkg::CFG_RESET;
      end else if (wr_i && cfg_sel) begin
         module_config_reg_ff <= wdata_i & protect_pkg::CFG_WR_MASK;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         protect_ctrl_reg_ff <= protect_pkg::PROT_RESET;
      end else if (wr_i && prot_sel) begin
         protect_ctrl_reg_ff <= wdata_i & protect_pkg::PROT_WR_MASK;
      end
   end

   always_comb begin
      rd_val = 32'h00000000;
      if (module_base_reg_hit) begin
         rd_val = {base_address_field_ff, 11'h000, base_valid_ff};
      end else if (cfg_sel) begin
         rd_val = module_config_reg_ff;
         rd_val[protect_pkg::CFG_ST_WD_BIT] = swe;
         rd_val[protect_pkg::CFG_ST_CYC_BIT] = cyc_active_ff;
         rd_val[protect_pkg::CFG_ST_RST_BIT] = sys_reset_ff;
      end else if (rst_sel) begin
         rd_val = {24'h000000, reset_status_reg_ff};
      end else if (prot_sel) begin
         rd_val = protect_ctrl_reg_ff;
      end
   end

   // Unmapped or refused reads return zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= rd_i ? rd_val : 32'h00000000;
      end
   end

   // Bus cycle tracking
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc_active_ff <= 1'b0;
         cyc_ext_ff <= 1'b0;
         cyc_intack_ff <= 1'b0;
      end else if (cyc_start_i) begin
         cyc_active_ff <= 1'b1;
         cyc_ext_ff <= cyc_ext_i;
         cyc_intack_ff <= cyc_intack_i;
      end else if (cyc_end_i || bm_tmo || sp_tmo) begin
         cyc_active_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         arb_seen_ff <= 1'b0;
      end else if (cyc_start_i) begin
         arb_seen_ff <= 1'b0;
      end else if (intack_arb_i) begin
         arb_seen_ff <= 1'b1;
      end
   end

   // Internal cycles always timed; external only when enabled
   assign bm_run = cyc_active_ff && !cyc_end_i && (!cyc_ext_ff || bme);
   assign bm_limit = protect_pkg::BM_MIN_CYCLES
                     << protect_ctrl_reg_ff[protect_pkg::PROT_BMT_LSB +: 2];
   // Spurious check has no enable on purpose
   assign sp_run = cyc_active_ff && cyc_intack_ff && !arb_seen_ff
                   && !intack_arb_i && !cyc_end_i;

   cycle_timer #(.W(protect_pkg::BM_W)) bus_mon_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .restart_i(cyc_start_i),
      .run_i(bm_run),
      .limit_i(bm_limit),
      .expired_o(bm_tmo)
   );

   cycle_timer #(.W(protect_pkg::BM_W)) spur_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .restart_i(cyc_start_i),
      .run_i(sp_run),
      .limit_i(protect_pkg::ARB_WIN_CYCLES),
      .expired_o(sp_tmo)
   );

   // Error goes to the core only; the pin driver stays off
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_err_ff <= 1'b0;
         pin_oe_ff <= 1'b0;
      end else begin
         bus_err_ff <= bm_tmo || sp_tmo;
         pin_oe_ff <= 1'b0;
      end
   end

   // Reset sources
   sync2 #(.W(2)) pin_sync_u (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({clk_loss_i, ext_rst_n_i}),
      .rst_val_i(2'b01),
      .q_o(pin_sync)
   );

   assign ext_req = !pin_sync[0];
   assign loc_req = pin_sync[1];
   assign dbf_req = halt_i && dbfe;
   assign sw_req = wd_tmo && !swri;
   assign any_req = ext_req || loc_req || dbf_req || sw_req || reset_instr_i;

   // Pin held low keeps reloading, so hold runs on after release
   always_comb begin
      nxt_rst_cnt = rst_cnt_ff;
      if (any_req) begin
         nxt_rst_cnt = protect_pkg::RST_HOLD_CYCLES;
      end else if (rst_cnt_ff != 10'h000) begin
         nxt_rst_cnt = rst_cnt_ff - 10'h001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_cnt_ff <= 10'h000;
         sys_reset_ff <= 1'b0;
      end else begin
         rst_cnt_ff <= nxt_rst_cnt;
         sys_reset_ff <= (nxt_rst_cnt != 10'h000);
      end
   end

   // Power-up shows after por; later causes overwrite it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reset_status_reg_ff <= protect_pkg::RST_STATUS_RESET;
      end else if (any_req) begin
         reset_status_reg_ff <= 8'h00;
         if (loc_req) begin
            reset_status_reg_ff[protect_pkg::RST_LOC_BIT] <= 1'b1;
         end else if (ext_req) begin
            reset_status_reg_ff[protect_pkg::RST_EXT_BIT] <= 1'b1;
         end else if (dbf_req) begin
            reset_status_reg_ff[protect_pkg::RST_DBF_BIT] <= 1'b1;
         end else if (sw_req) begin
            reset_status_reg_ff[protect_pkg::RST_SW_BIT] <= 1'b1;
         end else begin
            reset_status_reg_ff[protect_pkg::RST_INSTR_BIT] <= 1'b1;
         end
      end
   end

   // Watchdog service sequence; other writes may sit between keys
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wd_seq_ff <= protect_pkg::WD_IDLE;
      end else if (wr_i && svc_sel) begin
         unique case (wd_seq_ff)
            protect_pkg::WD_IDLE: begin
               if (wdata_i[7:0] == protect_pkg::WD_KEY_ARM) begin
                  wd_seq_ff <= protect_pkg::WD_ARMED;
               end
            end
            protect_pkg::WD_ARMED: begin
               if (wdata_i[7:0] == protect_pkg::WD_KEY_FIRE) begin
                  wd_seq_ff <= protect_pkg::WD_IDLE;
               end
            end
         endcase
      end
   end

   assign wd_service = wr_i && svc_sel && (wd_seq_ff == protect_pkg::WD_ARMED)
                       && (wdata_i[7:0] == protect_pkg::WD_KEY_FIRE);
   // Frozen while pending or resetting to avoid repeat expiries
   assign wd_run = swe && !wd_irq_ff && !sys_reset_ff;
   assign wd_limit = WD_BASE_CYCLES
                     << protect_ctrl_reg_ff[protect_pkg::PROT_SWT_LSB +: 3];

   cycle_timer #(.W(protect_pkg::WD_W)) wd_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .restart_i(wd_service || !swe),
      .run_i(wd_run),
      .limit_i(wd_limit),
      .expired_o(wd_tmo)
   );

   // Expiry wins over a service in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wd_irq_ff <= 1'b0;
         wd_lvl_ff <= 3'h0;
      end else if (wd_tmo && swri) begin
         wd_irq_ff <= 1'b1;
         wd_lvl_ff <= protect_pkg::IRQ_LEVEL_WD;
      end else if (wd_service || !swe) begin
         wd_irq_ff <= 1'b0;
         wd_lvl_ff <= 3'h0;
      end
   end

   assign rdata_o = rdata_ff;
   assign bus_err_o = bus_err_ff;
   assign bus_error_pin_oe_o = pin_oe_ff;
   assign sys_reset_o = sys_reset_ff;
   assign wd_irq_o = wd_irq_ff;
   assign wd_irq_level_o = wd_lvl_ff;
   assign reg_base_o = base_address_field_ff;
   assign freeze_en_o = module_config_reg_ff[protect_pkg::CFG_FRZ_BIT];
   assign show_mode_o = module_config_reg_ff[protect_pkg::CFG_SHOW_LSB +: 2];
   assign cs_func_o = module_config_reg_ff[protect_pkg::CFG_CSF_BIT];
   assign supv_only_o = module_config_reg_ff[protect_pkg::CFG_SUPV_BIT];
   assign iarb_o = module_config_reg_ff[protect_pkg::CFG_IARB_LSB +: 4];
   assign autovec_o = module_config_reg_ff[protect_pkg::CFG_AVEC_LSB +: 7];

   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_base_cpu_space: assert property (
      wr_i && module_base_reg_hit |=> base_address_field_ff == $past(wdata_i[31:12]))
      else $error("base register not loaded from cpu space write");
   a_window_decode: assert property (
      rd_i && !module_base_reg_hit && !win_hit |=> rdata_o == 32'h00000000)
      else $error("read outside window returned data");
   a_ro_bits_kept: assert property (
      wr_i && cfg_sel |=> (module_config_reg_ff & ~protect_pkg::CFG_WR_MASK) == 32'h0)
      else $error("read-only config bits stored");
   a_cfg_outputs: assert property (
      wr_i && cfg_sel |=> iarb_o == $past(wdata_i[3:0]) && show_mode_o == $past(wdata_i[9:8]))
      else $error("config outputs not updated");
   a_bm_min_limit: assert property (
      $rose(bm_tmo) |-> $past(cyc_active_ff, 64))
      else $error("bus monitor expired before 64 cycles");
   a_bm_error_out: assert property (
      bm_tmo |=> bus_err_o && !cyc_active_ff)
      else $error("timeout did not raise bus error");
   a_bm_ext_gate: assert property (
      bm_tmo |-> $past(!cyc_ext_ff || bme))
      else $error("disabled external cycle timed out");
   a_pin_quiet: assert property (
      bus_err_o |-> !bus_error_pin_oe_o)
      else $error("bus error pin driven");
   a_spurious_err: assert property (
      sp_tmo |=> bus_err_o ##1 !bus_err_o || sp_tmo || bm_tmo)
      else $error("spurious acknowledge not reported");
   a_cycle_restart: assert property (
      cyc_start_i |=> !bm_tmo && cyc_active_ff)
      else $error("bus monitor not restarted");
   a_dbf_reset: assert property (
      halt_i && dbfe && !loc_req && !ext_req
      |=> sys_reset_o && reset_status_reg_ff[protect_pkg::RST_DBF_BIT])
      else $error("double fault did not reset");
   a_wd_irq_path: assert property (
      wd_tmo && swri |=> wd_irq_o && wd_irq_level_o == protect_pkg::IRQ_LEVEL_WD)
      else $error("watchdog interrupt missing");
   a_wd_disabled: assert property (
      !swe |=> !wd_tmo)
      else $error("disabled watchdog expired");

   c_bus_timeout: cover property (bm_tmo);
   c_spurious: cover property (sp_tmo);
   c_wd_service: cover property (wd_service);
   c_dbf_reset: cover property (dbf_req ##1 sys_reset_o);
endmodule : sys_protect
`default_nettype wire

// >>> core_model.sv
// Behavioural processor core: one bus cycle per request, ends or arbitrates on cue.
// Assumes the bench requests one cycle at a time on the same clock.
`timescale 1ns/1ps
`default_nettype none
module core_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Bench control
   input wire logic go_i,
   input wire logic ext_i,
   input wire logic interrupt_acknowledge_cycle_i,
   input wire logic [9:0] end_at_i,
   input wire logic [9:0] arb_at_i,
   input wire logic fault_i,
   // Bus cycle side
   output logic cyc_start_o,
   output logic cyc_ext_o,
   output logic cyc_intack_o,
   output logic cyc_end_o,
   output logic intack_arb_o,
   output logic halt_o
);
   logic [9:0] cnt_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= 10'h000;
      end else if (go_i) begin
         cnt_ff <= 10'h001;
      end else if (cnt_ff != 10'h000 && cnt_ff != 10'h3ff) begin
         cnt_ff <= cnt_ff + 10'h001;
      end
   end
   // Qualifiers toggle outside a start so stale levels are never trusted
   always_ff @(posedge clk_i) begin
      cyc_start_o <= go_i;
      cyc_ext_o <= go_i ? ext_i : ~cyc_ext_o;
      cyc_intack_o <= go_i ? interrupt_acknowledge_cycle_i : ~cyc_intack_o;
      cyc_end_o <= end_at_i != 10'h000 && cnt_ff == end_at_i;
      intack_arb_o <= arb_at_i != 10'h000 && cnt_ff == arb_at_i;
      halt_o <= fault_i;
   end
endmodule : core_model
`default_nettype wire

// >>> test_system_protection_monitors.sv
// Bench for the protection monitors: register port, bus monitor, watchdog, resets.
// Assumes core_model on the bus-cycle side and a 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_system_protection_monitors;
   typedef struct packed {logic [11:0] ofs; logic we; logic [31:0] wd; logic [31:0] ex;} row_type;
   localparam row_type ROWS [5] = '{
      '{protect_pkg::OFS_RST_STATUS, 1'b0, 32'h0, 32'h00000040},
      '{protect_pkg::OFS_CONFIG, 1'b1, 32'hffffffff, 32'h007f538f},
      '{protect_pkg::OFS_CONFIG, 1'b1, 32'h0, 32'h0},
      '{protect_pkg::OFS_PROTECT, 1'b1, 32'hffffff80, 32'h00000300},
      '{12'h010, 1'b1, 32'hffffffff, 32'h0}};
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic go = 1'b0;
   logic ext = 1'b0;
   logic interrupt_acknowledge_cycle = 1'b0;
   logic fault = 1'b0;
   logic rsti = 1'b0;
   logic pin_rst_n = 1'b1;
   logic clk_loss = 1'b0;
   logic [31:0] addr_i = 32'h0;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] win = 32'h00010000;
   logic [3:0] fc = 4'h0;
   logic [9:0] end_at = 10'h0;
   logic [9:0] arb_at = 10'h0;
   logic [31:0] rdata_o, d;
   logic cs, ce, ci, cend, carb, halt, bus_error_pin, boe, srst, wirq, frz, csf, supv;
   logic [2:0] wlvl;
   logic [19:0] base;
   logic [1:0] shw;
   logic [3:0] iarb;
   logic [6:0] avec;
   int fails = 0;
   int compares = 0;
   int n;
   core_model u_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .ext_i(ext), .interrupt_acknowledge_cycle_i(interrupt_acknowledge_cycle),
      .end_at_i(end_at), .arb_at_i(arb_at), .fault_i(fault), .cyc_start_o(cs),
      .cyc_ext_o(ce), .cyc_intack_o(ci), .cyc_end_o(cend), .intack_arb_o(carb), .halt_o(halt));
   // Short watchdog base keeps the eight periods inside the run
   sys_protect #(.WD_BASE_CYCLES(24'h000010)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .function_code_bits_i(fc), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .cyc_start_i(cs), .cyc_ext_i(ce), .cyc_intack_i(ci),
      .cyc_end_i(cend), .intack_arb_i(carb), .halt_i(halt), .bus_err_o(bus_error_pin),
      .bus_error_pin_oe_o(boe), .ext_rst_n_i(pin_rst_n), .clk_loss_i(clk_loss),
      .reset_instr_i(rsti), .sys_reset_o(srst), .wd_irq_o(wirq), .wd_irq_level_o(wlvl),
      .reg_base_o(base), .freeze_en_o(frz), .show_mode_o(shw), .cs_func_o(csf),
      .supv_only_o(supv), .iarb_o(iarb), .autovec_o(avec));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // Gap cycle after each strobe so no strobe is set twice in one step
   task automatic wr(input logic [31:0] a, input logic [3:0] f, input logic [31:0] v);
      addr_i <= a;
      fc <= f;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [3:0] f);
      addr_i <= a;
      fc <= f;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
      @(posedge clk_i);
   endtask : rd
   task automatic wreg(input logic [11:0] o, input logic [31:0] v);
      wr(win | {20'h0, o}, 4'h5, v);
   endtask : wreg
   task automatic rreg(input logic [11:0] o);
      rd(win | {20'h0, o}, 4'h5);
   endtask : rreg
   // Ends on the edge at which the design takes the start
   task automatic cyc(input logic e, input logic i, input logic [9:0] ea, input logic [9:0] aa);
      ext <= e;
      interrupt_acknowledge_cycle <= i;
      end_at <= ea;
      arb_at <= aa;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
   endtask : cyc
   task automatic meas(input int s, input int lim);
      n = 0;
      for (int k = 1; k <= lim && n == 0; k++) begin
         @(posedge clk_i);
         #1;
         if ((s == 0 ? bus_error_pin : s == 1 ? wirq : s == 2 ? srst : !srst) === 1'b1) n = k;
      end
      @(posedge clk_i);
   endtask : meas
   initial begin
      #200000;
      fails++;
      print_verdict;
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      wr(protect_pkg::BASE_REG_ADDR, protect_pkg::FC_CPU_SPACE, 32'h00010001);
      chk({12'h0, base}, 32'h00010);
      for (int r = 0; r < 5; r++) begin
         if (ROWS[r].we) wreg(ROWS[r].ofs, ROWS[r].wd);
         rreg(ROWS[r].ofs);
         chk(d, ROWS[r].ex);
      end
      wreg(protect_pkg::OFS_CONFIG, 32'hffffffff);
      chk({16'h0, frz, shw, csf, supv, iarb, avec}, 32'h0000ffff);
      rd(win, 4'h1);
      chk(d, 32'h0);
      rd(win, 4'h7);
      chk(d, 32'h0);
      wr(protect_pkg::BASE_REG_ADDR, protect_pkg::FC_CPU_SPACE, 32'h00020001);
      rd(win, 4'h5);
      chk(d, 32'h0);
      win = 32'h00020000;
      rreg(protect_pkg::OFS_CONFIG);
      chk(d, 32'h007f538f);
      for (int b = 0; b < 4; b++) begin
         wreg(protect_pkg::OFS_PROTECT, 32'h40 | (b << 8));
         cyc(1'b1, 1'b0, 10'h0, 10'h0);
         meas(0, 600);
         chk(n, (64 << b) + 1);
      end
      wreg(protect_pkg::OFS_PROTECT, 32'h0);
      cyc(1'b1, 1'b0, 10'h0, 10'h0);
      meas(0, 600);
      chk(n, 0);
      cyc(1'b0, 1'b0, 10'h0, 10'h0);
      repeat (40) @(posedge clk_i);
      cyc(1'b0, 1'b0, 10'h0, 10'h0);
      meas(0, 600);
      chk(n, 65);
      chk(boe, 0);
      cyc(1'b0, 1'b0, 10'h00a, 10'h0);
      meas(0, 200);
      chk(n, 0);
      cyc(1'b0, 1'b1, 10'h0, 10'h0);
      meas(0, 100);
      chk(n, 17);
      cyc(1'b0, 1'b1, 10'h01e, 10'h005);
      meas(0, 100);
      chk(n, 0);
      fault <= 1'b1;
      meas(2, 6);
      chk(n, 0);
      wreg(protect_pkg::OFS_PROTECT, 32'h20);
      meas(2, 6);
      chk(n > 0, 1);
      fault <= 1'b0;
      meas(3, 700);
      rreg(protect_pkg::OFS_RST_STATUS);
      chk(d, 32'h10);
      wreg(protect_pkg::OFS_PROTECT, 32'h18);
      rreg(protect_pkg::OFS_CONFIG);
      chk(d, 32'h807f538f);
      repeat (6) begin
         wreg(protect_pkg::OFS_SERVICE, 32'h55);
         wreg(protect_pkg::OFS_CONFIG, 32'h0);
         wreg(protect_pkg::OFS_SERVICE, 32'haa);
      end
      chk(wirq, 0);
      wreg(protect_pkg::OFS_SERVICE, 32'haa);
      wreg(protect_pkg::OFS_SERVICE, 32'h55);
      meas(1, 40);
      chk({wirq, wlvl}, 4'hf);
      for (int s = 0; s < 8; s++) begin
         wreg(protect_pkg::OFS_PROTECT, 32'h0);
         wreg(protect_pkg::OFS_PROTECT, 32'h18 | s);
         meas(1, 3000);
         chk(n >= (16 << s) && n <= (16 << s) + 4, 1);
      end
      wreg(protect_pkg::OFS_PROTECT, 32'h0);
      wreg(protect_pkg::OFS_PROTECT, 32'h10);
      meas(2, 40);
      chk(n > 0, 1);
      wreg(protect_pkg::OFS_PROTECT, 32'h0);
      meas(3, 700);
      rreg(protect_pkg::OFS_RST_STATUS);
      chk(d, 32'h20);
      rsti <= 1'b1;
      @(posedge clk_i);
      rsti <= 1'b0;
      meas(2, 10);
      meas(3, 700);
      rreg(protect_pkg::OFS_RST_STATUS);
      chk(d, 32'h02);
      clk_loss <= 1'b1;
      @(posedge clk_i);
      clk_loss <= 1'b0;
      meas(2, 10);
      meas(3, 700);
      rreg(protect_pkg::OFS_RST_STATUS);
      chk(d, 32'h04);
      pin_rst_n <= 1'b0;
      @(posedge clk_i);
      pin_rst_n <= 1'b1;
      meas(2, 10);
      meas(3, 700);
      rreg(protect_pkg::OFS_RST_STATUS);
      chk(d, 32'h80);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({base, iarb}, 24'h00000f);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      wr(protect_pkg::BASE_REG_ADDR, protect_pkg::FC_CPU_SPACE, 32'h00010001);
      win = 32'h00010000;
      rreg(protect_pkg::OFS_RST_STATUS);
      chk(d, 32'h40);
      print_verdict;
   end
endmodule : test_system_protection_monitors
`default_nettype wire
